// ### include/ptts_pkg.sv
package ptts_pkg;

  // token and data widths
  localparam int TOK_W = 8;
  localparam int CNT_W = 5;
  localparam int QUEUE_DEPTH = 32;
  localparam int QUEUE_AW = 5;

  // register address of the token data port
  localparam logic [7:0] FIFO_DATA_ADDR = 8'h43;

  // transmit token codes
  localparam logic [7:0] TOK_SYNC1 = 8'h12;
  localparam logic [7:0] TOK_SYNC2 = 8'h13;
  localparam logic [7:0] TOK_SYNC3 = 8'h1b;
  localparam logic [7:0] TOK_RST1 = 8'h15;
  localparam logic [7:0] TOK_RST2 = 8'h16;
  localparam logic [7:0] TOK_EOP = 8'h14;
  localparam logic [7:0] TOK_CRC = 8'hff;
  localparam logic [7:0] TOK_OFF = 8'hfe;

  // inline transmit go command: pattern 101x_xxx1
  localparam logic [7:0] GO_MASK = 8'he1;
  localparam logic [7:0] GO_MATCH = 8'ha1;

  // packed payload header: top three bits 3'b100, low five bits the count
  localparam int HDR_POS = 5;
  localparam logic [2:0] HDR_CODE = 3'h4;

  // line symbol selector handed to the line coder
  typedef enum logic [3:0] {
    PTTS_SYM_NONE,
    PTTS_SYM_SYNC1,
    PTTS_SYM_SYNC2,
    PTTS_SYM_SYNC3,
    PTTS_SYM_RST1,
    PTTS_SYM_RST2,
    PTTS_SYM_EOP,
    PTTS_SYM_DATA,
    PTTS_SYM_CRC
  } ptts_sym_t;

  // one line action toward the coder
  typedef struct packed {
    ptts_sym_t sym;
    logic [3:0] nibble;
  } ptts_line_t;

  // software access to the token data port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ptts_host_t;

endpackage

// ### design/ptts_mem.sv
`timescale 1ns/100ps
// small dual-port store; read data comes from a register
module ptts_mem #(
  parameter int DW = 8,
  parameter int AW = 5
) (
  input wire logic core_clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // no reset on the array; contents are only read after being written
  always_ff @(posedge core_clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// ### design/ptts_queue.sv
`timescale 1ns/100ps
// transmit queue: push from software, pop by the sequencer
module ptts_queue #(
  parameter int DW = 8,
  parameter int AW = 5
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic push,
  input wire logic [DW-1:0] push_data,
  input wire logic pop,
  output logic [DW-1:0] head,
  output logic empty,
  output logic full
);

  logic [AW:0] wp_q;
  logic [AW:0] wp_d;
  logic [AW:0] rp_q;
  logic [AW:0] rp_d;
  logic do_push;
  logic do_pop;
  logic [AW-1:0] raddr;
  logic [DW-1:0] mem_rdata;
  logic fwd_q;
  logic fwd_d;
  logic [DW-1:0] fwd_data_q;
  logic [DW-1:0] fwd_data_d;

  assign empty = (wp_q == rp_q);
  assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign do_push = push && !full;
  assign do_pop = pop && !empty;

  // read address runs ahead so the head register shows the next entry
  assign raddr = rp_d[AW-1:0];

  // pointer next values; a push into a full queue is dropped
  always_comb
  begin
    wp_d = wp_q;
    rp_d = rp_q;
    if (do_push)
    begin
      wp_d = wp_q + 1'b1;
    end
    if (do_pop)
    begin
      rp_d = rp_q + 1'b1;
    end
  end

  // a push into the entry being read lands after the array read, so forward it;
  // without this a dry queue refilled mid-transmit shows a stale head
  always_comb
  begin
    fwd_d = do_push && (wp_q[AW-1:0] == raddr);
    fwd_data_d = push_data;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wp_q <= '0;
      rp_q <= '0;
      fwd_q <= 1'b0;
      fwd_data_q <= '0;
    end
    else
    begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      fwd_q <= fwd_d;
      fwd_data_q <= fwd_data_d;
    end
  end

  assign head = fwd_q ? fwd_data_q : mem_rdata;

  ptts_mem #(
    .DW(DW),
    .AW(AW)
  ) u_mem (
    .core_clk(core_clk),
    .we(do_push),
    .waddr(wp_q[AW-1:0]),
    .wdata(push_data),
    .raddr(raddr),
    .rdata(mem_rdata)
  );

endmodule

// ### design/ptts_sequencer.sv
`timescale 1ns/100ps
// Overview of operation
// - eight-bit tokens through one data register
// - own token codes translated to line symbols
// - one token at a time, finish before next
// - 101x_xxx1 write starts transmitter, not queued
// - sync tokens send sync ordered-set symbols
// - reset tokens send reset symbols
// - header 3'b100 plus count of payload bytes
// - low nibble first, each nibble encoded
// - 0xFF inserts hardware checksum
// - 0x14 sends end of packet
// - 0xFE turns the line driver off
// - write at 43h pushes, read pops receive
module ptts_sequencer #(
  parameter int QUEUE_AW = ptts_pkg::QUEUE_AW
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire ptts_pkg::ptts_host_t host,
  output logic [7:0] rdata,
  output logic rx_pop,
  input wire logic [7:0] rx_head,
  input wire logic tx_start,
  output ptts_pkg::ptts_line_t line,
  output logic line_valid,
  input wire logic line_ready,
  output logic driver_en,
  output logic tx_active,
  output logic tx_queue_empty,
  output logic tx_queue_full
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_DECODE,
    ST_SYMBOL,
    ST_LOW,
    ST_HIGH
  } ptts_state_t;

  ptts_state_t st_q;
  ptts_state_t st_d;
  logic run_q;
  logic run_d;
  logic drv_q;
  logic drv_d;
  logic [ptts_pkg::CNT_W-1:0] cnt_q;
  logic [ptts_pkg::CNT_W-1:0] cnt_d;
  logic pay_q;
  logic pay_d;
  logic [7:0] byte_q;
  logic [7:0] byte_d;
  ptts_pkg::ptts_line_t line_q;
  ptts_pkg::ptts_line_t line_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic port_hit;
  logic is_go;
  logic push;
  logic pop;
  logic [7:0] head;
  logic empty;
  logic full;

  // software port: the go command is swallowed, everything else is queued
  assign port_hit = (host.addr == ptts_pkg::FIFO_DATA_ADDR);
  assign is_go = (host.wdata & ptts_pkg::GO_MASK) == ptts_pkg::GO_MATCH;
  assign push = host.wr && port_hit && !is_go;
  assign rx_pop = host.rd && port_hit;

  ptts_queue #(
    .DW(ptts_pkg::TOK_W),
    .AW(QUEUE_AW)
  ) u_txq (
    .core_clk(core_clk),
    .rst(rst),
    .push(push),
    .push_data(host.wdata),
    .pop(pop),
    .head(head),
    .empty(empty),
    .full(full)
  );

  // receive data captured at the pop so the read value stays stable
  always_comb
  begin
    rdata_d = rdata_q;
    if (rx_pop)
    begin
      rdata_d = rx_head;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= 8'h00;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // pop only in fetch; the memory head needs one cycle to settle after a pop
  assign pop = (st_q == ST_FETCH) && !empty;

  // token interpreter
  always_comb
  begin
    st_d = st_q;
    run_d = run_q;
    drv_d = drv_q;
    cnt_d = cnt_q;
    pay_d = pay_q;
    byte_d = byte_q;
    line_d = line_q;
    case (st_q)
      ST_IDLE:
      begin
        if (run_q && !empty)
        begin
          st_d = ST_FETCH;
        end
      end
      ST_FETCH:
      begin
        // queue ran dry: stop and wait for a new start
        if (empty)
        begin
          st_d = ST_IDLE;
          run_d = 1'b0;
        end
        else
        begin
          byte_d = head;
          st_d = ST_DECODE;
        end
      end
      ST_DECODE:
      begin
        st_d = ST_SYMBOL;
        line_d.nibble = 4'h0;
        if (pay_q)
        begin
          st_d = ST_LOW;
        end
        else if (byte_q[7:ptts_pkg::HDR_POS] == ptts_pkg::HDR_CODE)
        begin
          cnt_d = byte_q[ptts_pkg::CNT_W-1:0];
          pay_d = (byte_q[ptts_pkg::CNT_W-1:0] != 5'h00);
          st_d = ST_FETCH;
        end
        else
        begin
          case (byte_q)
            ptts_pkg::TOK_SYNC1: line_d.sym = ptts_pkg::PTTS_SYM_SYNC1;
            ptts_pkg::TOK_SYNC2: line_d.sym = ptts_pkg::PTTS_SYM_SYNC2;
            ptts_pkg::TOK_SYNC3: line_d.sym = ptts_pkg::PTTS_SYM_SYNC3;
            ptts_pkg::TOK_RST1: line_d.sym = ptts_pkg::PTTS_SYM_RST1;
            ptts_pkg::TOK_RST2: line_d.sym = ptts_pkg::PTTS_SYM_RST2;
            ptts_pkg::TOK_CRC: line_d.sym = ptts_pkg::PTTS_SYM_CRC;
            ptts_pkg::TOK_EOP: line_d.sym = ptts_pkg::PTTS_SYM_EOP;
            ptts_pkg::TOK_OFF:
            begin
              drv_d = 1'b0;
              st_d = ST_FETCH;
            end
            default:
            begin
              st_d = ST_FETCH;
            end
          endcase
          // any symbol turns the driver on before it goes out
          if (st_d == ST_SYMBOL)
          begin
            drv_d = 1'b1;
          end
        end
      end
      ST_SYMBOL:
      begin
        if (line_ready)
        begin
          st_d = ST_FETCH;
        end
      end
      ST_LOW:
      begin
        line_d.sym = ptts_pkg::PTTS_SYM_DATA;
        line_d.nibble = byte_q[3:0];
        drv_d = 1'b1;
        st_d = ST_HIGH;
      end
      ST_HIGH:
      begin
        if (line_ready)
        begin
          // pay_q still high here means the low nibble was the one taken
          if (pay_q)
          begin
            line_d.nibble = byte_q[7:4];
            pay_d = 1'b0;
          end
          else
          begin
            st_d = ST_FETCH;
          end
        end
      end
      default:
      begin
        st_d = ST_IDLE;
      end
    endcase
    // after the high nibble is taken, count the payload byte down
    if (st_q == ST_HIGH && line_ready && !pay_q)
    begin
      cnt_d = cnt_q - 1'b1;
      pay_d = (cnt_q != 5'h01);
    end
    // a start wins over a dry fetch in the same cycle, so it is never lost
    if ((host.wr && port_hit && is_go) || tx_start)
    begin
      run_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= ST_IDLE;
      run_q <= 1'b0;
      drv_q <= 1'b0;
      cnt_q <= '0;
      pay_q <= 1'b0;
      byte_q <= 8'h00;
      line_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      run_q <= run_d;
      drv_q <= drv_d;
      cnt_q <= cnt_d;
      pay_q <= pay_d;
      byte_q <= byte_d;
      line_q <= line_d;
    end
  end

  // a nibble or symbol is offered while waiting in the two send states
  assign line_valid = (st_q == ST_SYMBOL) || (st_q == ST_HIGH);
  assign line = line_q;
  assign rdata = rdata_q;
  assign driver_en = drv_q;
  assign tx_active = run_q;
  assign tx_queue_empty = empty;
  assign tx_queue_full = full;

endmodule

// ### dv/ptts_seq_asserts.sv
`timescale 1ns/100ps
// port checks on the sequencer
module ptts_seq_asserts (
  input wire logic core_clk,
  input wire logic rst,
  input wire ptts_pkg::ptts_host_t host,
  input wire logic [7:0] rdata,
  input wire logic rx_pop,
  input wire logic [7:0] rx_head,
  input wire ptts_pkg::ptts_line_t line,
  input wire logic line_valid,
  input wire logic line_ready,
  input wire logic driver_en,
  input wire logic tx_active,
  input wire logic tx_queue_empty,
  input wire logic tx_queue_full
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic hit, go, acc;
  // go decode uses the full mask so b1h-style writes count as well
  assign hit = host.addr == ptts_pkg::FIFO_DATA_ADDR;
  assign go = host.wr && hit && (host.wdata & ptts_pkg::GO_MASK) == ptts_pkg::GO_MATCH;
  assign acc = line_valid && line_ready;
  stall_hold_a: assert property (
    line_valid && !line_ready |=> line_valid && $stable(line)) else $error("stall moved");
  go_start_a: assert property (
    go && !tx_active |=> tx_active) else $error("go ignored");
  go_unqueued_a: assert property (
    go && tx_queue_empty && !tx_active |=> tx_queue_empty) else $error("go queued");
  sym_known_a: assert property (
    line_valid |-> line.sym != ptts_pkg::PTTS_SYM_NONE) else $error("no symbol");
  rd_pop_a: assert property (
    rx_pop == (host.rd && hit)) else $error("bad pop");
  rd_data_a: assert property (
    rx_pop |=> rdata == $past(rx_head)) else $error("bad rdata");
  wr_push_a: assert property (
    host.wr && hit && !go && tx_queue_empty && !tx_active |=> !tx_queue_empty)
    else $error("push lost");
  drv_on_a: assert property (
    acc |=> driver_en) else $error("driver off");
  cover property (acc && line.sym == ptts_pkg::PTTS_SYM_DATA);
  cover property (line_valid && !line_ready ##1 acc);
  cover property (tx_queue_full);
  cover property (go && tx_queue_empty && !tx_active);
endmodule
bind ptts_sequencer ptts_seq_asserts chk (.core_clk(core_clk), .rst(rst), .host(host),
  .rdata(rdata), .rx_pop(rx_pop), .rx_head(rx_head), .line(line), .line_valid(line_valid),
  .line_ready(line_ready), .driver_en(driver_en), .tx_active(tx_active),
  .tx_queue_empty(tx_queue_empty), .tx_queue_full(tx_queue_full));

// ### dv/ptts_coder_model.sv
`timescale 1ns/100ps
// line coder stand-in; slow mode accepts one cycle in three, like a busy shifter
module ptts_coder_model (
  input wire logic core_clk,
  input wire logic slow,
  output logic line_ready
);
  logic [1:0] cnt = 2'h0;
  initial line_ready = 1'b0;
  // every nibble is taken on its own handshake
  always @(negedge core_clk)
  begin
    cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
    line_ready <= !slow || cnt == 2'h2;
  end
endmodule

// ### dv/tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR %0t: got %h want %h", $time, a, b); end end
module tb_top;
  logic core_clk = 0, rst = 1, tx_start = 0, slow = 0, line_valid, line_ready, rx_pop;
  logic driver_en, tx_active, tx_queue_empty, tx_queue_full;
  logic [7:0] rdata, rx_head = 8'h00;
  ptts_pkg::ptts_host_t host = '0;
  ptts_pkg::ptts_line_t line;
  ptts_pkg::ptts_line_t got[$], exp_q[$];
  int mismatches = 0, check_count = 0, cyc = 0;
  always #50 core_clk = ~core_clk;
  ptts_sequencer DUT (.core_clk(core_clk), .rst(rst), .host(host), .rdata(rdata),
    .rx_pop(rx_pop), .rx_head(rx_head), .tx_start(tx_start), .line(line),
    .line_valid(line_valid), .line_ready(line_ready), .driver_en(driver_en),
    .tx_active(tx_active), .tx_queue_empty(tx_queue_empty), .tx_queue_full(tx_queue_full));
  ptts_coder_model coder (.core_clk(core_clk), .slow(slow), .line_ready(line_ready));
  // log each accepted line action; hang guard alongside
  always @(posedge core_clk)
  begin
    if (line_valid && line_ready) got.push_back(line);
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      test_done();
    end
  end
  function automatic ptts_pkg::ptts_line_t e(ptts_pkg::ptts_sym_t s, logic [3:0] n = 4'h0);
    return {s, n};
  endfunction
  // one host cycle, read or write, at the given address
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] b);
    @(negedge core_clk);
    host = '{wr: w, rd: !w, addr: a, wdata: b};
    @(negedge core_clk);
    host = '0;
  endtask
  task automatic send(input logic [7:0] t[$]);
    foreach (t[k]) acc(1'b1, ptts_pkg::FIFO_DATA_ADDR, t[k]);
  endtask
  // wait for the transmit to start and drain, then compare the line log
  task automatic run_cmp(input string name);
    int i;
    for (i = 0; i < 20 && tx_active !== 1'b1; i++) @(negedge core_clk);
    for (i = 0; i < 1000 && (tx_active !== 1'b0 || line_valid !== 1'b0); i++)
      @(negedge core_clk);
    `CHK(got.size(), exp_q.size())
    foreach (exp_q[k]) if (k < got.size()) `CHK(got[k], exp_q[k])
    $display("test %s done", name);
    got = {};
    exp_q = {};
  endtask
  task automatic t_rx();
    rx_head = 8'h5c;
    acc(1'b0, ptts_pkg::FIFO_DATA_ADDR, 8'h00);
    `CHK(rdata, 8'h5c)
    rx_head = 8'h77;
    acc(1'b0, 8'h42, 8'h00);
    `CHK(rdata, 8'h5c)
    $display("test rx done");
  endtask
  task automatic t_syms();
    send('{8'h12, 8'h13, 8'h1b, 8'h33, 8'h15, 8'h16, 8'h14, 8'hfe, 8'ha1});
    exp_q = '{e(ptts_pkg::PTTS_SYM_SYNC1), e(ptts_pkg::PTTS_SYM_SYNC2),
      e(ptts_pkg::PTTS_SYM_SYNC3), e(ptts_pkg::PTTS_SYM_RST1), e(ptts_pkg::PTTS_SYM_RST2),
      e(ptts_pkg::PTTS_SYM_EOP)};
    run_cmp("syms");
    `CHK(driver_en, 1'b0)
  endtask
  task automatic t_packed();
    slow = 1;
    send('{8'h83, 8'h5a, 8'h12, 8'hc3, 8'hff, 8'h14, 8'hfe});
    @(negedge core_clk) tx_start = 1;
    @(negedge core_clk) tx_start = 0;
    exp_q = '{e(ptts_pkg::PTTS_SYM_DATA, 4'ha), e(ptts_pkg::PTTS_SYM_DATA, 4'h5),
      e(ptts_pkg::PTTS_SYM_DATA, 4'h2), e(ptts_pkg::PTTS_SYM_DATA, 4'h1),
      e(ptts_pkg::PTTS_SYM_DATA, 4'h3), e(ptts_pkg::PTTS_SYM_DATA, 4'hc),
      e(ptts_pkg::PTTS_SYM_CRC), e(ptts_pkg::PTTS_SYM_EOP)};
    run_cmp("packed");
    `CHK(driver_en, 1'b0)
    slow = 0;
  endtask
  task automatic t_full();
    repeat (32) acc(1'b1, ptts_pkg::FIFO_DATA_ADDR, 8'h33);
    `CHK(tx_queue_full, 1'b1)
    acc(1'b1, ptts_pkg::FIFO_DATA_ADDR, 8'h12); // dropped: a sync here would show in the log
    send('{8'ha1});
    run_cmp("full");
    `CHK(tx_queue_empty, 1'b1)
  endtask
  // go on an empty queue, then tokens written while the transmitter waits
  task automatic t_late();
    send('{8'ha1});
    `CHK(tx_active, 1'b1)
    `CHK(tx_queue_empty, 1'b1)
    send('{8'h12, 8'h14, 8'hfe});
    exp_q = '{e(ptts_pkg::PTTS_SYM_SYNC1), e(ptts_pkg::PTTS_SYM_EOP)};
    run_cmp("late");
    `CHK(driver_en, 1'b0)
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge core_clk);
    @(negedge core_clk) rst = 0;
    t_rx();
    t_syms();
    t_packed();
    t_full();
    t_late();
    test_done();
  end
endmodule
